// ===== hw/spb_defines.svh
// register offsets, reset values, masks and bit positions for the serial pin port block
`ifndef SPB_DEFINES_SVH
`define SPB_DEFINES_SVH
`define SPB_OFS_PORT_CTL 8'h00
`define SPB_OFS_PORT_DAT 8'h04
`define SPB_OFS_BIT_RATE 8'h08
`define SPB_OFS_SER_CTL 8'h0C
`define SPB_OFS_SER_MODE 8'h10
`define SPB_RST_PORT_CTL 16'hA888
`define SPB_RST_PORT_DAT 8'h00
`define SPB_RST_BIT_RATE 8'hFF
`define SPB_RST_SER_CTL 8'h00
`define SPB_RST_SER_MODE 8'h00
`define SPB_DAT_WR_MASK 8'h7F
`define SPB_PRE_MASK_N1 6'h03
`define SPB_PRE_MASK_N2 6'h0F
`define SPB_PRE_MASK_N3 6'h3F
`define SPB_SCTL_TE 5
`define SPB_SCTL_RE 4
`define SPB_SCTL_CLOCK_ENABLE_HI 1
`define SPB_SCTL_CLOCK_ENABLE_LO 0
`define SPB_SMOD_SYNC 7
`define SPB_RESP_OKAY 2'h0
`define SPB_RESP_SLVERR 2'h2
`endif

// ===== hw/spb_pkg.sv
// types shared by the serial pin port block
package spb_pkg;
  typedef enum logic [1:0] {
    SPB_PIN_OFF = 2'b00,
    SPB_PIN_OUT = 2'b01,
    SPB_PIN_IN = 2'b10,
    SPB_PIN_IN_ALT = 2'b11
  } spb_pin_mode_e;
endpackage

// ===== hw/spb_top.sv
// serial pin port control and bit rate generator with an axi4-lite slave
//
// Summary of operation
// - only low control and data bits steer pins
// - clock mode: 00 off, 01 drive, 10 read
// - clock mode resets to input, code 10
// - output drives clock bit; input reads pin
// - clock bit: 0 low, 1 high, reset 0
// - break mode 01 drives break bit onto txd
// - receive enable makes break bit read rxd
// - break bit reset value is not guaranteed
// - eight-bit rate register with clock select
// - rate register always readable, writable only outside standby
// - rate register all ones on reset, standby
// - one generator and register per channel
// - divider follows source clock, rate, factor
// - divider 0 to 255, source n 0-3
`timescale 1ns/1ps
`default_nettype none
`include "spb_defines.svh"
module spb_top
  import spb_pkg::*;
(
  input wire logic aclk, // system clock 50 mhz
  input wire logic aresetn, // sync reset, active low
  input wire logic standby, // standby entry level
  input wire logic module_standby, // module standby level
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic sck_in, // clock pin level
  output logic sck_out, // clock pin drive value
  output logic sck_oe, // clock pin drive enable
  input wire logic rxd_in, // receive pin level
  output logic txd_out, // transmit pin break value
  output logic txd_oe, // transmit pin break enable
  output logic brg_tick // one pulse per bit rate period
);
  // register storage
  logic [15:0] port_ctl_reg; // serial_pin_port_control
  logic [7:0] port_dat_reg; // serial_pin_port_data
  logic [7:0] bit_rate_reg; // bit_rate_divider
  logic [7:0] ser_ctl_reg; // serial_control_reg copy
  logic [7:0] ser_mode_reg; // serial_mode_reg copy
  // write channel state
  logic aw_held_reg; // address taken, waiting
  logic w_held_reg; // data taken, waiting
  logic [7:0] aw_addr_reg; // held write address
  logic [31:0] w_data_reg; // held write data
  logic [3:0] w_strb_reg; // held strobes
  logic bvalid_reg; // response pending
  logic [1:0] bresp_reg; // response code
  logic rvalid_reg; // read data pending
  logic [31:0] rdata_reg; // read data
  logic [1:0] rresp_reg; // read response code
  // generator state
  logic [5:0] pre_cnt_reg; // source prescaler
  logic [7:0] brg_cnt_reg; // divider counter
  logic brg_tick_reg; // tick pulse
  logic sck_out_reg; // clock pin value
  logic sck_oe_reg; // clock pin enable
  logic txd_out_reg; // break value
  logic txd_oe_reg; // break enable
  // decoded controls
  logic aw_hs, w_hs, wr_do, ar_hs; // handshakes
  logic wr_ok; // write address mapped
  logic stby; // any standby
  logic src_en; // selected source edge
  logic br_wr; // rate register written
  logic [7:0] rd_val; // read mux value
  logic rd_ok; // read address mapped
  spb_pin_mode_e ck_mode, bk_mode; // pin modes
  assign stby = standby | module_standby;
  assign ck_mode = spb_pin_mode_e'(port_ctl_reg[3:2]);
  assign bk_mode = spb_pin_mode_e'(port_ctl_reg[1:0]);
  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs = s_axi_wvalid & s_axi_wready;
  assign ar_hs = s_axi_arvalid & s_axi_arready;
  // write happens once both halves are held
  assign wr_do = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wr_ok = (aw_addr_reg == `SPB_OFS_PORT_CTL) || (aw_addr_reg == `SPB_OFS_PORT_DAT) ||
                 (aw_addr_reg == `SPB_OFS_BIT_RATE) || (aw_addr_reg == `SPB_OFS_SER_CTL) ||
                 (aw_addr_reg == `SPB_OFS_SER_MODE);
  assign br_wr = wr_do & (aw_addr_reg == `SPB_OFS_BIT_RATE) & w_strb_reg[0];
  assign s_axi_awready = ~aw_held_reg;
  assign s_axi_wready = ~w_held_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign sck_out = sck_out_reg;
  assign sck_oe = sck_oe_reg;
  assign txd_out = txd_out_reg;
  assign txd_oe = txd_oe_reg;
  assign brg_tick = brg_tick_reg;

  // capture write address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else begin
      if (aw_hs) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end else if (wr_do) begin
        aw_held_reg <= 1'b0;
      end
      if (w_hs) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_do) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // write response, slverr for unmapped offsets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `SPB_RESP_OKAY;
    end else if (wr_do) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_ok ? `SPB_RESP_OKAY : `SPB_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // register writes by byte lane
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_ctl_reg <= `SPB_RST_PORT_CTL;
      port_dat_reg <= `SPB_RST_PORT_DAT;
      ser_ctl_reg <= `SPB_RST_SER_CTL;
      ser_mode_reg <= `SPB_RST_SER_MODE;
    end else if (wr_do) begin
      case (aw_addr_reg)
        `SPB_OFS_PORT_CTL: begin
          if (w_strb_reg[0]) port_ctl_reg[7:0] <= w_data_reg[7:0];
          if (w_strb_reg[1]) port_ctl_reg[15:8] <= w_data_reg[15:8];
        end
        `SPB_OFS_PORT_DAT: begin
          // top bit stays read-only
          if (w_strb_reg[0]) port_dat_reg <= w_data_reg[7:0] & `SPB_DAT_WR_MASK;
        end
        `SPB_OFS_SER_CTL: begin
          if (w_strb_reg[0]) ser_ctl_reg <= w_data_reg[7:0];
        end
        `SPB_OFS_SER_MODE: begin
          if (w_strb_reg[0]) ser_mode_reg <= w_data_reg[7:0];
        end
        default: begin
          // other offsets store nothing
        end
      endcase
    end
  end

  // rate register, forced to all ones by standby
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_rate_reg <= `SPB_RST_BIT_RATE;
    end else if (stby) begin
      bit_rate_reg <= `SPB_RST_BIT_RATE;
    end else if (br_wr) begin
      bit_rate_reg <= w_data_reg[7:0];
    end
  end

  // read value mux with live pin levels
  always_comb begin
    rd_val = 8'h00;
    rd_ok = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `SPB_OFS_PORT_CTL: rd_val = 8'h00;
      `SPB_OFS_PORT_DAT: begin
        rd_val = port_dat_reg;
        // input modes return clock pin level
        if (ck_mode == SPB_PIN_IN || ck_mode == SPB_PIN_IN_ALT) rd_val[1] = sck_in;
        // receive enable returns receive pin level
        if (ser_ctl_reg[`SPB_SCTL_RE]) rd_val[0] = rxd_in;
      end
      `SPB_OFS_BIT_RATE: rd_val = bit_rate_reg;
      `SPB_OFS_SER_CTL: rd_val = ser_ctl_reg;
      `SPB_OFS_SER_MODE: rd_val = ser_mode_reg;
      default: rd_ok = 1'b0;
    endcase
  end

  // read channel, answer one cycle after address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `SPB_RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_ok ? `SPB_RESP_OKAY : `SPB_RESP_SLVERR;
      if ({s_axi_araddr[7:2], 2'b00} == `SPB_OFS_PORT_CTL)
        rdata_reg <= {16'h0000, port_ctl_reg};
      else
        rdata_reg <= {24'h00_0000, rd_val};
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // pin drivers, registered one cycle behind the registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_out_reg <= 1'b0;
      sck_oe_reg <= 1'b0;
      txd_out_reg <= 1'b0;
      txd_oe_reg <= 1'b0;
    end else begin
      sck_oe_reg <= (ck_mode == SPB_PIN_OUT);
      sck_out_reg <= port_dat_reg[1];
      txd_oe_reg <= (bk_mode == SPB_PIN_OUT);
      txd_out_reg <= port_dat_reg[0];
    end
  end

  // source select: n 0..3 is div 1, 4, 16, 64
  always_comb begin
    case (ser_mode_reg[1:0])
      2'b00: src_en = 1'b1;
      2'b01: src_en = (pre_cnt_reg & `SPB_PRE_MASK_N1) == `SPB_PRE_MASK_N1;
      2'b10: src_en = (pre_cnt_reg & `SPB_PRE_MASK_N2) == `SPB_PRE_MASK_N2;
      default: src_en = (pre_cnt_reg & `SPB_PRE_MASK_N3) == `SPB_PRE_MASK_N3;
    endcase
  end

  // divider: n+1 source edges per tick, restart on write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt_reg <= 6'h00;
      brg_cnt_reg <= 8'h00;
      brg_tick_reg <= 1'b0;
    end else if (stby || br_wr) begin
      pre_cnt_reg <= 6'h00;
      brg_cnt_reg <= 8'h00;
      brg_tick_reg <= 1'b0;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 6'h01;
      brg_tick_reg <= 1'b0;
      if (src_en) begin
        if (brg_cnt_reg == bit_rate_reg) begin
          brg_cnt_reg <= 8'h00;
          brg_tick_reg <= 1'b1;
        end else begin
          brg_cnt_reg <= brg_cnt_reg + 8'h01;
        end
      end
    end
  end

  // checks on design behaviour
  AST_CK_DRIVE: assert property (@(posedge aclk) disable iff (!aresetn)
    (ck_mode == SPB_PIN_OUT) |=> (sck_oe && sck_out == $past(port_dat_reg[1])))
    else $error("clock pin not driven in output mode");
  AST_CK_QUIET: assert property (@(posedge aclk) disable iff (!aresetn)
    (ck_mode != SPB_PIN_OUT) |=> !sck_oe)
    else $error("clock pin driven outside output mode");
  AST_CTL_RESET: assert property (@(posedge aclk)
    $rose(aresetn) |-> (port_ctl_reg == `SPB_RST_PORT_CTL && !sck_oe && !txd_oe))
    else $error("control reset value wrong");
  AST_BRK_DRIVE: assert property (@(posedge aclk) disable iff (!aresetn)
    txd_oe == $past(aresetn && bk_mode == SPB_PIN_OUT))
    else $error("break enable mismatch");
  AST_RX_READ: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_hs && {s_axi_araddr[7:2], 2'b00} == `SPB_OFS_PORT_DAT && ser_ctl_reg[`SPB_SCTL_RE])
    |=> (rdata_reg[0] == $past(rxd_in) && rdata_reg[7] == 1'b0))
    else $error("break bit read not receive pin");
  AST_BR_STBY: assert property (@(posedge aclk) disable iff (!aresetn)
    stby |=> (bit_rate_reg == `SPB_RST_BIT_RATE && brg_cnt_reg == 8'h00))
    else $error("rate register not set by standby");
  AST_BR_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    (br_wr && !stby) |=> (bit_rate_reg == $past(w_data_reg[7:0]) && brg_cnt_reg == 8'h00))
    else $error("rate register write lost");
  AST_TICK: assert property (@(posedge aclk) disable iff (!aresetn)
    (src_en && brg_cnt_reg == bit_rate_reg && !stby && !br_wr)
    |=> (brg_tick && brg_cnt_reg == 8'h00))
    else $error("tick not raised at terminal count");
  // a zero divider at full source rate ticks every cycle, so a zero divider is left out here at every source rate
  AST_TICK_ONE: assert property (@(posedge aclk) disable iff (!aresetn)
    (brg_tick && bit_rate_reg != 8'h00) |=> !brg_tick)
    else $error("tick longer than one cycle");
  AST_FAST_TICK: assert property (@(posedge aclk) disable iff (!aresetn)
    (brg_tick && ser_mode_reg[1:0] == 2'b00 && bit_rate_reg == 8'h01 && !stby && !br_wr)
    ##1 (ser_mode_reg[1:0] == 2'b00 && bit_rate_reg == 8'h01 && !stby && !br_wr)
    |-> !brg_tick ##1 brg_tick)
    else $error("tick period wrong for n zero");
  AST_BRESP: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_do |=> s_axi_bvalid)
    else $error("write response missing");
  COV_CK_OUT: cover property (@(posedge aclk) disable iff (!aresetn) $rose(sck_oe));
  COV_BREAK: cover property (@(posedge aclk) disable iff (!aresetn) $rose(txd_oe));
  COV_TICK: cover property (@(posedge aclk) disable iff (!aresetn) brg_tick);
  COV_STBY: cover property (@(posedge aclk) disable iff (!aresetn) $rose(stby));
endmodule // spb_top
`default_nettype wire

// ===== bench/spb_pin_model.sv
// far serial device as seen on the clock and receive pins
`timescale 1ns/1ps
`default_nettype none
module spb_pin_model (
  input wire logic sck_out, // block clock pin value
  input wire logic sck_oe, // block clock pin enable
  input wire logic ext_sck, // level the far device puts on sck
  input wire logic ext_rxd, // level the far device sends on rxd
  output logic sck_in, // resolved clock pin level
  output logic rxd_in // receive pin level
);
  // block wins the clock wire while it drives, far device otherwise
  assign sck_in = sck_oe ? sck_out : ext_sck;
  // far device always drives its transmit line
  assign rxd_in = ext_rxd;
endmodule // spb_pin_model
`default_nettype wire

// ===== bench/tb_spb_top.sv
// self-checking bench for the serial pin port block
`timescale 1ns/1ps
`default_nettype none
`include "spb_defines.svh"
module tb_spb_top;
  logic aclk = 1'b0, aresetn = 1'b0, standby = 1'b0, module_standby = 1'b0; // clock, resets
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00; // addresses
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0; // write handshakes
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0; // read handshakes
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata; // data
  logic [3:0] s_axi_wstrb = 4'hF; // all lanes
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid; // slave flags
  logic [1:0] s_axi_bresp, s_axi_rresp; // responses
  logic sck_in, sck_out, sck_oe, rxd_in, txd_out, txd_oe, brg_tick; // pins
  logic ext_sck = 1'b1, ext_rxd = 1'b0; // far device levels
  int n_fail = 0, num_checks = 0; // counters
  int seed = 32'hE5325CBC; // fixed seed
  logic [31:0] r; // random word
  logic [65:0] ent; // popped note
  logic [65:0] rq[$]; // read notes: mask, resp, data
  logic [1:0] bq[$]; // write notes
  // 50 mhz clock
  always #10 aclk = ~aclk;
  spb_top DUT (.aclk, .aresetn, .standby, .module_standby, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sck_in, .sck_out, .sck_oe,
    .rxd_in, .txd_out, .txd_oe, .brg_tick);
  spb_pin_model PEER (.sck_out, .sck_oe, .ext_sck, .ext_rxd, .sck_in, .rxd_in);
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // write: offer address and data together, release each when taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    bq.push_back(er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta = ta || (s_axi_awvalid && s_axi_awready);
      tw = tw || (s_axi_wvalid && s_axi_wready);
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  // read: note expected word, mask and response first
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
    rq.push_back({m, er, e});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  // pin drive check: sck_oe, sck_out, txd_oe, txd_out
  task pins(input logic [3:0] e);
    repeat (2) @(negedge aclk);
    chk("pins", {28'h0, e}, {28'h0, sck_oe, sck_out, txd_oe, txd_out});
  endtask
  // cycles between two generator ticks
  task period(input int e);
    int c;
    c = 0;
    do @(negedge aclk); while (!brg_tick);
    do begin
      @(negedge aclk);
      c++;
    end while (!brg_tick);
    chk("tick period", e, c);
  endtask
  // monitor: take the oldest note at each response handshake
  always @(negedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      ent = rq.pop_front();
      chk("rdata", ent[31:0] & ent[65:34], s_axi_rdata & ent[65:34]);
      chk("rresp", {30'h0, ent[33:32]}, {30'h0, s_axi_rresp});
    end
    if (s_axi_bvalid && s_axi_bready) chk("bresp", {30'h0, bq.pop_front()}, {30'h0, s_axi_bresp});
  end
  // main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`SPB_OFS_PORT_CTL, 32'hA888, 32'hFFFFFFFF, 2'h0);
    rd(`SPB_OFS_PORT_DAT, 32'h2, 32'hFFFFFFFE, 2'h0);
    rd(`SPB_OFS_BIT_RATE, 32'hFF, 32'hFFFFFFFF, 2'h0);
    rd(8'h14, 32'h0, 32'hFFFFFFFF, 2'h2);
    wr(8'h14, 32'h0, 2'h2);
    wr(`SPB_OFS_SER_CTL, 32'h0, 2'h0);
    wr(`SPB_OFS_SER_MODE, 32'h0, 2'h0);
    wr(`SPB_OFS_PORT_CTL, 32'hFFF4, 2'h0);
    rd(`SPB_OFS_PORT_CTL, 32'hFFF4, 32'hFFFFFFFF, 2'h0);
    wr(`SPB_OFS_PORT_DAT, 32'hFF, 2'h0);
    pins(4'b1101);
    rd(`SPB_OFS_PORT_DAT, 32'h7F, 32'hFFFFFFFF, 2'h0);
    wr(`SPB_OFS_PORT_DAT, 32'h0, 2'h0);
    pins(4'b1000);
    wr(`SPB_OFS_PORT_CTL, 32'h1, 2'h0);
    wr(`SPB_OFS_PORT_DAT, 32'h1, 2'h0);
    pins(4'b0011);
    wr(`SPB_OFS_PORT_DAT, 32'h0, 2'h0);
    pins(4'b0010);
    wr(`SPB_OFS_PORT_CTL, 32'h2, 2'h0);
    pins(4'b0000);
    for (int m = 2; m < 4; m++) begin
      wr(`SPB_OFS_PORT_CTL, (m << 2) | m, 2'h0);
      pins(4'b0000);
      for (int v = 0; v < 2; v++) begin
        ext_sck <= v[0];
        rd(`SPB_OFS_PORT_DAT, v << 1, 32'h2, 2'h0);
      end
    end
    wr(`SPB_OFS_SER_CTL, 32'h10, 2'h0);
    repeat (4) begin
      r = $random(seed);
      ext_rxd <= r[0];
      rd(`SPB_OFS_PORT_DAT, r, 32'h1, 2'h0);
    end
    repeat (4) begin
      r = $random(seed);
      wr(`SPB_OFS_BIT_RATE, r, 2'h0);
      rd(`SPB_OFS_BIT_RATE, r & 32'hFF, 32'hFFFFFFFF, 2'h0);
    end
    wr(`SPB_OFS_BIT_RATE, 32'h1, 2'h0);
    for (int n = 0; n < 4; n++) begin
      wr(`SPB_OFS_SER_MODE, n, 2'h0);
      period(2 << (2 * n));
    end
    wr(`SPB_OFS_SER_MODE, 32'h0, 2'h0);
    wr(`SPB_OFS_BIT_RATE, 32'h0, 2'h0);
    period(1);
    wr(`SPB_OFS_BIT_RATE, 32'hFF, 2'h0);
    period(256);
    for (int k = 0; k < 2; k++) begin
      wr(`SPB_OFS_BIT_RATE, 32'h5, 2'h0);
      @(posedge aclk);
      standby <= (k == 0);
      module_standby <= (k == 1);
      @(posedge aclk);
      standby <= 1'b0;
      module_standby <= 1'b0;
      rd(`SPB_OFS_BIT_RATE, 32'hFF, 32'hFFFFFFFF, 2'h0);
    end
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    rd(`SPB_OFS_PORT_CTL, 32'hA888, 32'hFFFFFFFF, 2'h0);
    tally_and_finish;
  end
  // watchdog well beyond the expected run
  initial begin
    #400000;
    n_fail++;
    tally_and_finish;
  end
endmodule // tb_spb_top
`default_nettype wire
